// [logic/aacq_pkg.sv]
// aacq_pkg: constants, register map and types of the acquisition control block.
// assumes a 100 MHz system clock and a word-addressed register bus.
package aacq_pkg;
   // ---------------------------------------------------------------
   // clocking and pacer reference
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned PACER_REF_HZ = 2_000_000;
   localparam int unsigned REF_DIV_CYC = CLK_HZ / PACER_REF_HZ;
   localparam int REF_CNT_W = $clog2(REF_DIV_CYC);
   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CHANNEL = 4'h0;
   localparam logic [3:0] REG_GAIN = 4'h1;
   localparam logic [3:0] REG_MODE = 4'h2;
   localparam logic [3:0] REG_SOFT_TRIG = 4'h3;
   localparam logic [3:0] REG_RESULT_LOW = 4'h4;
   localparam logic [3:0] REG_RESULT_HIGH = 4'h5;
   localparam logic [3:0] REG_IRQ_CLEAR = 4'h6;
   localparam logic [3:0] REG_EVENT_STATUS = 4'h7;
   localparam logic [3:0] REG_EVENT_MASK = 4'h8;
   localparam logic [3:0] REG_DIVISOR1 = 4'h9;
   localparam logic [3:0] REG_DIVISOR2 = 4'ha;
   localparam logic [3:0] REG_ACQ_CONTROL = 4'hb;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int READY_N_BIT = 7;
   localparam int EV_DONE_BIT = 0;
   localparam int EV_OVERRUN_BIT = 1;
   localparam int EV_W = 2;
   localparam int RESULT_W = 12;
   localparam int DIV_W = 16;
   localparam logic [2:0] CHANNEL_RST = 3'h0;
   localparam logic [DIV_W-1:0] DIVISOR_RST = 16'h0000;
   localparam logic [EV_W-1:0] EV_MASK_RST = 2'h0;
   // ---------------------------------------------------------------
   // enumerations
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      GAIN_X1 = 3'h0, GAIN_X2 = 3'h1, GAIN_X4 = 3'h2, GAIN_X8 = 3'h3, GAIN_X16 = 3'h4
   } aacq_gain_t;
   typedef enum logic [2:0] {
      MODE_SW_POLL = 3'h0, MODE_SW_INT = 3'h1, MODE_EXT_POLL = 3'h2,
      MODE_EXT_INT = 3'h3, MODE_TMR_POLL = 3'h4, MODE_TMR_INT = 3'h5
   } aacq_mode_t;
   typedef enum logic [1:0] {SRC_SW = 2'h0, SRC_EXT = 2'h1, SRC_TMR = 2'h2} aacq_src_t;
   typedef enum logic [0:0] {CONV_IDLE = 1'b0, CONV_BUSY = 1'b1} aacq_conv_t;
endpackage : aacq_pkg

// [logic/aacq_pacer_if.sv]
// aacq_pacer_if: divisors, run and tick between the control core and the pacer.
// assumes both ends sit on the same system clock.
`timescale 1ns/10ps
interface aacq_pacer_if;
   logic [15:0] div1;
   logic [15:0] div2;
   logic run;
   logic tick;
   modport ctrl (output div1, output div2, output run, input tick);
   modport pacer (input div1, input div2, input run, output tick);
endinterface : aacq_pacer_if

// [logic/aacq_edge_sync.sv]
// aacq_edge_sync: brings an external level into sys_clk and flags its rising edge.
// assumes the input may change at any time relative to sys_clk.
`timescale 1ns/10ps
module aacq_edge_sync
   import aacq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic async_in,
   output logic rise
);
   logic meta;
   logic sync;
   logic sync_d;

   // two-stage synchroniser, then a delayed copy for the edge
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
         sync_d <= 1'b0;
         rise <= 1'b0;
      end else if (clk_en) begin
         meta <= async_in;
         sync <= meta;
         sync_d <= sync;
         rise <= sync & ~sync_d;
      end
   end

   chk_edge_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise |=> !rise) else $error("edge flag lasted more than one cycle");
endmodule : aacq_edge_sync

// [logic/aacq_pacer.sv]
// aacq_pacer: 2 MHz reference prescaler and two cascaded 16-bit dividers.
// assumes divisors change only while the pacer is stopped.
`timescale 1ns/10ps
module aacq_pacer
   import aacq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   aacq_pacer_if.pacer pif
);
   logic [REF_CNT_W-1:0] pre;
   logic [DIV_W-1:0] cnt1;
   logic [DIV_W-1:0] cnt2;
   logic ref_tick;
   logic stage1;
   logic go;

   // a zero divisor stops the pacer outright
   function automatic logic div_ok(input logic [DIV_W-1:0] d);
      return d != '0;
   endfunction : div_ok

   assign go = pif.run && div_ok(pif.div1) && div_ok(pif.div2);
   assign ref_tick = (pre == REF_CNT_W'(REF_DIV_CYC - 1));
   assign stage1 = ref_tick && (cnt1 == pif.div1 - 16'h0001);

   // prescaler and both dividers restart from zero whenever halted
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pre <= '0;
         cnt1 <= '0;
         cnt2 <= '0;
         pif.tick <= 1'b0;
      end else if (clk_en) begin
         pif.tick <= 1'b0;
         if (!go) begin
            pre <= '0;
            cnt1 <= '0;
            cnt2 <= '0;
         end else begin
            pre <= ref_tick ? '0 : pre + 1'b1;
            if (ref_tick) cnt1 <= stage1 ? '0 : cnt1 + 16'h0001;
            if (stage1) begin
               cnt2 <= (cnt2 == pif.div2 - 16'h0001) ? '0 : cnt2 + 16'h0001;
               pif.tick <= (cnt2 == pif.div2 - 16'h0001);
            end
         end
      end
   end

   chk_pacer_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pif.tick |-> $past(go)) else $error("pacer ticked while stopped or zero");
   chk_pacer_ref: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pre <= REF_CNT_W'(REF_DIV_CYC - 1)) else $error("prescaler out of range");
   cov_pacer_tick: cover property (@(posedge sys_clk) disable iff (!rst_n) pif.tick);
endmodule : aacq_pacer

// [logic/aacq_ctrl.sv]
// aacq_ctrl: acquisition control top with Avalon-MM register slave.
// assumes an external converter that pulses adc_done with adc_data per start.
//
// Function
// - eight inputs; channel register keeps three bits, host writes 0 to 7
// - channel selection is 0 after reset
// - five gain codes for x1, x2, x4, x8, x16
// - gain x1, bipolar, after reset
// - six modes: sw, ext, timer source, each polled then interrupt
// - reset mode is software trigger with polled transfer, code 0
// - soft trigger write gives one start pulse, result lands in index 4 and 5
// - 12-bit result, ready bit driven low once result is valid
// - no new interrupt request until host clears the pending one
// - pacer rate is reference over both 16-bit divisors
// - stopping disables hardware triggers and halts the pacer
// - channel and gain hold for all conversions until rewritten
// - a zero divisor stops pacer triggers
// - pacer reference runs at 2 MHz
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module aacq_ctrl
   import aacq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ext_trig,
   output logic adc_start,
   output logic [2:0] adc_channel,
   output aacq_gain_t adc_gain,
   input wire logic adc_done,
   input wire logic [RESULT_W-1:0] adc_data,
   output logic irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   aacq_mode_t mode;
   aacq_conv_t conv_state;
   logic ack;
   logic acq_run;
   logic [RESULT_W-1:0] result;
   logic data_ready_n;
   logic [EV_W-1:0] ev_status;
   logic [EV_W-1:0] ev_mask;
   logic irq_pend;
   logic ext_rise;
   logic [31:0] next_readdata;
   logic wr_take;
   logic soft_go;
   logic hw_go;
   logic trig;
   logic done_ev;
   logic overrun_ev;
   aacq_pacer_if pif ();

   // ---------------------------------------------------------------
   // mode decoding
   // ---------------------------------------------------------------
   function automatic aacq_src_t mode_src(input aacq_mode_t m);
      return aacq_src_t'(m[2:1]);
   endfunction : mode_src

   function automatic logic mode_int(input aacq_mode_t m);
      return m[0];
   endfunction : mode_int

   function automatic logic wr_hit(input logic take, input logic [3:0] a, input logic [3:0] r);
      return take && (a == r);
   endfunction : wr_hit

   // ---------------------------------------------------------------
   // bus slave: one wait state on every access while clk_en is high
   // ---------------------------------------------------------------
   // registered ack keeps read data timing simple at the cost of a cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) ack <= 1'b0;
      else if (clk_en) ack <= (avs_read | avs_write) & ~ack;
   end

   // a frozen clock keeps the master waiting, else a write would be acked but never land
   assign avs_waitrequest = (avs_read | avs_write) & ~(ack & clk_en);
   assign wr_take = avs_write & ack & clk_en & avs_byteenable[0];

   // read mux; unmapped indices read zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
         REG_CHANNEL: next_readdata[2:0] = adc_channel;
         REG_GAIN: next_readdata[2:0] = adc_gain;
         REG_MODE: next_readdata[2:0] = mode;
         REG_RESULT_LOW: next_readdata[7:0] = result[7:0];
         REG_RESULT_HIGH: begin
            next_readdata[3:0] = result[11:8];
            next_readdata[READY_N_BIT] = data_ready_n;
         end
         REG_EVENT_STATUS: next_readdata[EV_W-1:0] = ev_status;
         REG_EVENT_MASK: next_readdata[EV_W-1:0] = ev_mask;
         REG_DIVISOR1: next_readdata[DIV_W-1:0] = pif.div1;
         REG_DIVISOR2: next_readdata[DIV_W-1:0] = pif.div2;
         REG_ACQ_CONTROL: next_readdata[0] = acq_run;
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   // read data latched on the edge that raises ack, valid while wait is low
   always_ff @(posedge sys_clk) begin
      if (!rst_n) avs_readdata <= 32'h0000_0000;
      else if (clk_en && avs_read && !ack) avs_readdata <= next_readdata;
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   // channel and gain drive the front end directly and change only on writes
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         adc_channel <= CHANNEL_RST;
         adc_gain <= GAIN_X1;
      end else begin
         if (wr_hit(wr_take, avs_address, REG_CHANNEL)) adc_channel <= avs_writedata[2:0];
         if (wr_hit(wr_take, avs_address, REG_GAIN) && avs_writedata[2:0] <= GAIN_X16)
            adc_gain <= aacq_gain_t'(avs_writedata[2:0]);
      end
   end

   // undefined mode codes are ignored so the block never enters a dead mode
   always_ff @(posedge sys_clk) begin
      if (!rst_n) mode <= MODE_SW_POLL;
      else if (wr_hit(wr_take, avs_address, REG_MODE) && avs_writedata[2:0] <= MODE_TMR_INT)
         mode <= aacq_mode_t'(avs_writedata[2:0]);
   end

   // divisors and the run bit feed the pacer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pif.div1 <= DIVISOR_RST;
         pif.div2 <= DIVISOR_RST;
         acq_run <= 1'b0;
      end else begin
         if (wr_hit(wr_take, avs_address, REG_DIVISOR1)) pif.div1 <= avs_writedata[DIV_W-1:0];
         if (wr_hit(wr_take, avs_address, REG_DIVISOR2)) pif.div2 <= avs_writedata[DIV_W-1:0];
         if (wr_hit(wr_take, avs_address, REG_ACQ_CONTROL)) acq_run <= avs_writedata[0];
      end
   end

   assign pif.run = acq_run && (mode_src(mode) == SRC_TMR);

   // ---------------------------------------------------------------
   // triggers
   // ---------------------------------------------------------------
   aacq_edge_sync u_ext (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(ext_trig),
      .rise(ext_rise)
   );

   aacq_pacer u_pacer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pif(pif)
   );

   // software trigger acts only in the software-source modes
   assign soft_go = wr_hit(wr_take, avs_address, REG_SOFT_TRIG) && (mode_src(mode) == SRC_SW);
   assign hw_go = clk_en && acq_run &&
      ((mode_src(mode) == SRC_EXT && ext_rise) || (mode_src(mode) == SRC_TMR && pif.tick));
   assign trig = soft_go | hw_go;

   // ---------------------------------------------------------------
   // conversion sequencer
   // ---------------------------------------------------------------
   // a trigger arriving mid-conversion is dropped and reported as overrun
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         conv_state <= CONV_IDLE;
         adc_start <= 1'b0;
         result <= '0;
         data_ready_n <= 1'b1;
      end else if (clk_en) begin
         adc_start <= 1'b0;
         case (conv_state)
            CONV_IDLE: begin
               if (trig) begin
                  adc_start <= 1'b1;
                  data_ready_n <= 1'b1;
                  conv_state <= CONV_BUSY;
               end
            end
            CONV_BUSY: begin
               if (adc_done) begin
                  result <= adc_data;
                  data_ready_n <= 1'b0;
                  conv_state <= CONV_IDLE;
               end
            end
            default: conv_state <= CONV_IDLE;
         endcase
      end
   end

   assign done_ev = clk_en && conv_state == CONV_BUSY && adc_done;
   assign overrun_ev = trig && conv_state == CONV_BUSY;

   // ---------------------------------------------------------------
   // events and interrupt
   // ---------------------------------------------------------------
   // sticky events, write one to clear; a new event wins over its clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ev_status <= '0;
         ev_mask <= EV_MASK_RST;
      end else begin
         if (wr_hit(wr_take, avs_address, REG_EVENT_STATUS))
            ev_status <= ev_status & ~avs_writedata[EV_W-1:0] | {overrun_ev, done_ev};
         else
            ev_status <= ev_status | {overrun_ev, done_ev};
         if (wr_hit(wr_take, avs_address, REG_EVENT_MASK)) ev_mask <= avs_writedata[EV_W-1:0];
      end
   end

   // interrupt-mode request stays up until the host clears it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) irq_pend <= 1'b0;
      else if (done_ev && mode_int(mode)) irq_pend <= 1'b1;
      else if (wr_hit(wr_take, avs_address, REG_IRQ_CLEAR)) irq_pend <= 1'b0;
   end

   assign irq = irq_pend | (|(ev_status & ev_mask));

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_reset_chan: assert property ($past(!rst_n) |-> adc_channel == 3'h0)
      else $error("channel not zero after reset");
   chk_reset_gain: assert property ($past(!rst_n) |-> adc_gain == GAIN_X1)
      else $error("gain not x1 after reset");
   chk_reset_mode: assert property ($past(!rst_n) |-> mode == MODE_SW_POLL)
      else $error("mode not software polled after reset");
   chk_gain_range: assert property (adc_gain <= GAIN_X16)
      else $error("gain code out of range");
   chk_mode_range: assert property (mode <= MODE_TMR_INT)
      else $error("mode code out of range");
   chk_chan_write: assert property (wr_hit(wr_take, avs_address, REG_CHANNEL)
      |=> adc_channel == $past(avs_writedata[2:0])) else $error("channel write lost");
   chk_soft_start: assert property (soft_go && conv_state == CONV_IDLE
      |=> adc_start ##1 !adc_start) else $error("soft trigger gave no single pulse");
   chk_result_ready: assert property (done_ev
      |=> !data_ready_n && result == $past(adc_data)) else $error("result not presented");
   chk_irq_hold: assert property (irq_pend && !wr_hit(wr_take, avs_address, REG_IRQ_CLEAR)
      |=> irq_pend) else $error("interrupt request dropped without clear");
   chk_stop_quiet: assert property (!acq_run && !soft_go
      |=> !adc_start) else $error("conversion started while stopped");
   chk_cfg_stable: assert property (!wr_take
      |=> $stable(adc_channel) && $stable(adc_gain)) else $error("channel or gain moved");
   chk_ext_edge: assert property (adc_start && mode_src(mode) == SRC_EXT
      |-> $past(ext_rise)) else $error("external start without edge");
   chk_bus_answer: assert property ((avs_read | avs_write) && clk_en
      |-> ##[0:1] !avs_waitrequest) else $error("bus answer late");

   cov_soft_conv: cover property (soft_go ##[1:50] done_ev);
   cov_irq_clear: cover property (irq_pend ##[1:50] !irq_pend);
   cov_overrun: cover property (overrun_ev);
   cov_ext_conv: cover property (hw_go && mode_src(mode) == SRC_EXT);
endmodule : aacq_ctrl

// [verif/aacq_conv_model.sv]
// aacq_conv_model: behavioural converter on the far side of the start/done pair.
// assumes one start pulse per conversion; latency is set by the bench.
`timescale 1ns/10ps
module aacq_conv_model (
   input wire logic sys_clk,
   input wire logic adc_start,
   input wire logic [2:0] adc_channel,
   input wire logic [2:0] adc_gain,
   input wire logic [31:0] lat,
   output logic adc_done,
   output logic [11:0] adc_data
);
   int unsigned cnt = 0;
   logic [11:0] res = 12'h000;
   initial begin
      adc_done = 1'b0;
      adc_data = 12'h000;
   end
   // result encodes channel and gain so the bench can see what was sampled
   always @(posedge sys_clk) begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data; // stale data toggles, never a held copy
      if (adc_start === 1'b1) begin
         cnt <= (lat == 0) ? 1 : lat;
         res <= {adc_channel, 1'b0, adc_gain, 5'h15};
      end else if (cnt == 1) begin
         adc_done <= 1'b1;
         adc_data <= res;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule : aacq_conv_model

// [verif/tb_adc_acquisition_control.sv]
// tb_adc_acquisition_control: self-checking bench for the acquisition control block.
// assumes the register map of aacq_pkg and a converter model on the far side.
`timescale 1ns/10ps
module tb_adc_acquisition_control;
   import aacq_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic ext_trig = 1'b0;
   logic adc_start;
   logic [2:0] adc_channel;
   aacq_gain_t adc_gain;
   logic adc_done;
   logic [11:0] adc_data;
   logic irq;
   int unsigned lat = 4;
   int err_count = 0;
   int checks_done = 0;
   int starts = 0;
   int cyc = 0;
   int last_at = 0;
   int prev_at = 0;
   int s0;
   logic [31:0] rd;

   aacq_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_trig(ext_trig), .adc_start(adc_start), .adc_channel(adc_channel), .adc_gain(adc_gain),
      .adc_done(adc_done), .adc_data(adc_data), .irq(irq));
   aacq_conv_model conv_u (.sys_clk(sys_clk), .adc_start(adc_start), .adc_channel(adc_channel),
      .adc_gain(adc_gain), .lat(lat), .adc_done(adc_done), .adc_data(adc_data));

   // ---------------------------------------------------------------
   // clock, start counter and shared tasks
   // ---------------------------------------------------------------
   always #5 sys_clk = ~sys_clk;
   // start pulses and their spacing, for pacer and one-shot checks
   always @(posedge sys_clk) begin
      cyc++;
      if (adc_start === 1'b1) begin
         starts++;
         prev_at = last_at;
         last_at = cyc;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // one Avalon access; waitrequest and read data are taken at the rising edge itself
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 50) chk(1'b1, 1'b0, "bus hang");
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // let the write settle before the caller looks at outputs
      @(negedge sys_clk);
   endtask : bus
   task rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk(rd[7:0], exp, what);
   endtask : rchk
   // polls the ready flag, then checks both result bytes; channel 5 and gain x8 hold from t_soft on
   task conv_check();
      int n;
      n = 0;
      do begin
         bus(1'b0, REG_RESULT_HIGH, 32'h0);
         n++;
      end while (rd[READY_N_BIT] !== 1'b0 && n < 40);
      chk(rd[7:0], {4'h0, 3'h5, 1'b0}, "result high");
      rchk(REG_RESULT_LOW, {GAIN_X8, 5'h15}, "result low");
   endtask : conv_check
   task ext_pulse();
      @(posedge sys_clk);
      ext_trig <= 1'b1;
      repeat (5) @(posedge sys_clk);
      ext_trig <= 1'b0;
      repeat (12) @(negedge sys_clk);
   endtask : ext_pulse

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset();
      chk(adc_channel, 3'h0, "reset channel");
      chk(adc_gain, GAIN_X1, "reset gain");
      chk(irq, 1'b0, "reset irq");
      rchk(REG_MODE, 8'h00, "reset mode");
      rchk(REG_EVENT_MASK, 8'h00, "reset mask");
      rchk(4'hc, 8'h00, "unmapped read");
   endtask : t_reset
   task t_select();
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, REG_CHANNEL, i);
         chk(adc_channel, i[2:0], "channel");
      end
      @(posedge sys_clk);
      avs_byteenable <= 4'h0;
      bus(1'b1, REG_CHANNEL, 32'h2);
      @(posedge sys_clk);
      avs_byteenable <= 4'hf;
      chk(adc_channel, 3'h7, "masked write");
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, REG_GAIN, i);
         chk(adc_gain, (i < 5) ? i[2:0] : 3'h4, "gain");
      end
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, REG_MODE, i);
         rchk(REG_MODE, (i < 6) ? i[7:0] : 8'h05, "mode");
      end
      bus(1'b1, 4'hd, 32'hff);
      rchk(4'hd, 8'h00, "unmapped write");
   endtask : t_select
   task t_soft();
      bus(1'b1, REG_MODE, MODE_SW_POLL);
      bus(1'b1, REG_CHANNEL, 32'h5);
      bus(1'b1, REG_GAIN, GAIN_X8);
      s0 = starts;
      bus(1'b1, REG_SOFT_TRIG, 32'h1);
      conv_check();
      bus(1'b1, REG_SOFT_TRIG, 32'h1);
      conv_check();
      chk(starts - s0, 2, "soft starts");
   endtask : t_soft
   task t_irq();
      bus(1'b1, REG_EVENT_MASK, 32'h1);
      bus(1'b1, REG_SOFT_TRIG, 32'h1);
      conv_check();
      chk(irq, 1'b1, "masked in irq");
      rchk(REG_EVENT_STATUS, 8'h01, "done status");
      bus(1'b1, REG_EVENT_STATUS, 32'h1);
      chk(irq, 1'b0, "w1c irq");
      bus(1'b1, REG_EVENT_MASK, 32'h0);
      bus(1'b1, REG_MODE, MODE_SW_INT);
      bus(1'b1, REG_SOFT_TRIG, 32'h1);
      conv_check();
      chk(irq, 1'b1, "int mode irq");
      bus(1'b1, REG_SOFT_TRIG, 32'h1);
      conv_check();
      chk(irq, 1'b1, "irq held");
      bus(1'b1, REG_IRQ_CLEAR, 32'h1);
      chk(irq, 1'b0, "irq cleared");
      bus(1'b1, REG_EVENT_STATUS, 32'h3);
      bus(1'b1, REG_MODE, MODE_SW_POLL);
   endtask : t_irq
   task t_overrun();
      lat = 30; // long conversion so the second trigger lands while busy
      s0 = starts;
      bus(1'b1, REG_SOFT_TRIG, 32'h1);
      bus(1'b1, REG_SOFT_TRIG, 32'h1);
      conv_check();
      chk(starts - s0, 1, "busy trigger dropped");
      rchk(REG_EVENT_STATUS, 8'h03, "overrun status");
      bus(1'b1, REG_EVENT_STATUS, 32'h3);
      rchk(REG_EVENT_STATUS, 8'h00, "status cleared");
      lat = 4;
   endtask : t_overrun
   task t_ext();
      bus(1'b1, REG_MODE, MODE_EXT_POLL);
      s0 = starts;
      ext_pulse();
      chk(starts - s0, 0, "ext while stopped");
      bus(1'b1, REG_ACQ_CONTROL, 32'h1);
      ext_pulse();
      chk(starts - s0, 1, "one start per edge");
      conv_check();
      // a pulse that comes and goes while the clock enable is low must leave no start
      s0 = starts;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      ext_pulse();
      @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (8) @(negedge sys_clk);
      chk(starts - s0, 0, "edge seen while frozen");
      bus(1'b1, REG_ACQ_CONTROL, 32'h0);
   endtask : t_ext
   task t_pacer();
      bus(1'b1, REG_MODE, MODE_TMR_POLL);
      bus(1'b1, REG_DIVISOR1, 32'h1);
      bus(1'b1, REG_ACQ_CONTROL, 32'h1);
      s0 = starts;
      repeat (300) @(negedge sys_clk);
      chk(starts - s0, 0, "zero divisor");
      bus(1'b1, REG_ACQ_CONTROL, 32'h0);
      bus(1'b1, REG_DIVISOR2, 32'h2);
      bus(1'b1, REG_ACQ_CONTROL, 32'h1);
      repeat (360) @(negedge sys_clk);
      chk(starts - s0 >= 3, 1'b1, "pacer running");
      chk(last_at - prev_at, REF_DIV_CYC * 1 * 2, "pacer period");
      conv_check();
      bus(1'b1, REG_ACQ_CONTROL, 32'h0);
      s0 = starts;
      repeat (300) @(negedge sys_clk);
      chk(starts - s0, 0, "pacer halted");
   endtask : t_pacer

   // ---------------------------------------------------------------
   // sequence, watchdog and verdict
   // ---------------------------------------------------------------
   task stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      t_reset();
      t_select();
      t_soft();
      t_irq();
      t_overrun();
      t_ext();
      t_pacer();
      stop_test();
   end
   // the whole run needs well under two thousand cycles; this bound leaves ample slack
   initial begin
      repeat (30000) @(posedge sys_clk);
      err_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      stop_test();
   end
endmodule : tb_adc_acquisition_control
